// [verilog/apf_axis_follower.sv]
// Purpose: position tracking, follower and secondary axis step logic of one motion axis
// Assumes: pair inputs synchronous to clk; firmware writes registers on the plain port
// Notes: pair 0 is lines 13-14, pair 1 is 15-16, pair 2 is 17-18; a on odd line, b on even
`timescale 1ns/1ps
// Overview of operation
// - count every step pulse issued to the primary drive
// - without encoder feedback, position is step count divided by motor scale
// - with encoder feedback, position is encoder count divided by encoder scale
// - encoder pulses on pairs 13 and 14 accumulate in the encoder counter
// - quadrature counts every edge of both channels, four per line
// - relative moves still scale by motor scale; position comes from encoder
// - follower clock comes from pair 13-14, 15-16 or 17-18 set as ratio input
// - follower enable makes primary steps track the selected clock input
// - primary step rate equals input count rate times follower scale
// - secondary drive uses pair 15-16, else pair 13-14, set for ratio mode
// - secondary ratio enable makes secondary steps follow primary steps scaled
// - a secondary ratio of two or more, or of minus two or less, is refused with error 9004
// - fault lamp lights on any error only while lamp enable is set
// - line direction field one makes the pair an output, zero an input
// - clock type two is step/direction, one is quadrature
module apf_axis_follower (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic [2:0] pair_in_a,
	input wire logic [2:0] pair_in_b,
	output logic [2:0] pair_out_a,
	output logic [2:0] pair_out_b,
	output logic [2:0] pair_oe,
	output logic step_out,
	output logic dir_out,
	output logic fault_lamp
);
	typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_DONE} apf_div_type;

	apf_pkg::apf_ctrl_type ctrl;
	apf_pkg::apf_line_type line_setup [3];
	logic [31:0] motor_scale;
	logic [31:0] encoder_scale;
	logic [31:0] follower_scale;
	logic [31:0] secondary_ratio;
	logic [31:0] step_pulse_counter;
	logic [31:0] encoder_pulse_counter;
	logic [31:0] position_user_units;
	logic [15:0] error_code;
	logic [31:0] move_left;
	logic move_dir;
	logic [2:0] prev_a;
	logic [2:0] prev_b;
	logic [apf_pkg::GAP_W-1:0] gap [2];
	logic [1:0] step_hi;
	logic [1:0] step_dir;
	apf_div_type div_state;
	logic [31:0] div_quo;
	logic [31:0] div_rem;
	logic [31:0] div_den;
	logic [4:0] div_cnt;
	logic div_neg;

	logic [1:0] evt;
	logic [1:0] evt_dir;
	logic [1:0] fol_sel;
	logic fol_active;
	logic sec_on_15;
	logic sec_on_13;
	logic sec_active;
	logic ratio_ok;
	logic [32:0] div_sh;
	logic [63:0] move_prod;
	apf_pkg::apf_step_type enc_evt;
	apf_pkg::apf_step_type fol_in;
	apf_pkg::apf_step_type fol_out;
	apf_pkg::apf_step_type sec_out;
	apf_pkg::apf_step_type pri_step;

	function automatic logic wr_hit(logic [7:0] a, logic [7:0] ofs, logic en);
		return en && (a == ofs);
	endfunction

	// secondary output pair: output, step/direction type, ratio mode
	function automatic logic sec_pair_ok(apf_pkg::apf_line_type cfg);
		return cfg.is_output && cfg.ratio && (cfg.clk_type == apf_pkg::CLK_STEP_DIR);
	endfunction

	// step event from a clock input, by its configured clock type
	function automatic apf_pkg::apf_step_type src_step(apf_pkg::apf_line_type cfg,
		logic [1:0] prev, logic [1:0] now);
		apf_pkg::apf_step_type s;
		s = apf_pkg::quad_step(prev, now);
		if (cfg.clk_type == apf_pkg::CLK_STEP_DIR) begin
			s.pulse = !prev[1] && now[1];
			s.dir = now[0];
		end
		return s;
	endfunction

	// source selection and event decode
	always_comb begin
		fol_sel = (ctrl.follower_source == 2'h3) ? 2'h0 : ctrl.follower_source;
		fol_active = ctrl.follower_enable && (ctrl.follower_source != 2'h3)
			&& !line_setup[fol_sel].is_output && line_setup[fol_sel].ratio
			&& (line_setup[fol_sel].clk_type == apf_pkg::CLK_QUAD
			|| line_setup[fol_sel].clk_type == apf_pkg::CLK_STEP_DIR);
		fol_in = src_step(line_setup[fol_sel], {prev_a[fol_sel], prev_b[fol_sel]},
			{pair_in_a[fol_sel], pair_in_b[fol_sel]});
		fol_in.pulse = fol_in.pulse && fol_active;
		enc_evt = apf_pkg::quad_step({prev_a[0], prev_b[0]}, {pair_in_a[0], pair_in_b[0]});
		enc_evt.pulse = enc_evt.pulse && !line_setup[0].is_output
			&& (line_setup[0].clk_type == apf_pkg::CLK_QUAD);
		sec_on_15 = sec_pair_ok(line_setup[1]);
		sec_on_13 = sec_pair_ok(line_setup[0]);
		sec_active = ctrl.secondary_ratio_enable && (sec_on_15 || sec_on_13);
		if (fol_active) begin
			evt[0] = fol_out.pulse;
			evt_dir[0] = fol_out.dir;
		end else begin
			evt[0] = (move_left != 32'h0) && (gap[0] == '0);
			evt_dir[0] = move_dir;
		end
		evt[1] = sec_out.pulse;
		evt_dir[1] = sec_out.dir;
		// primary step as seen by the secondary scaler
		pri_step.pulse = evt[0];
		pri_step.dir = evt_dir[0];
		ratio_ok = ($signed(wr_data) > apf_pkg::RATIO_MIN) && ($signed(wr_data) < apf_pkg::RATIO_MAX);
		move_prod = 64'(apf_pkg::apf_abs(wr_data)) * 64'(motor_scale);
		div_sh = {div_rem, div_quo[31]};
	end

	apf_ratio_scaler u_follower (
		.clk(clk),
		.rst_b(rst_b),
		.enable(fol_active),
		.ratio(follower_scale),
		.in_step(fol_in),
		.out_ready(gap[0] == '0),
		.out_step(fol_out)
	);

	apf_ratio_scaler u_secondary (
		.clk(clk),
		.rst_b(rst_b),
		.enable(sec_active),
		.ratio(secondary_ratio),
		.in_step(pri_step),
		.out_ready(gap[1] == '0),
		.out_step(sec_out)
	);

	// configuration registers; a refused ratio keeps the old value
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl <= apf_pkg::RST_CTRL;
			motor_scale <= apf_pkg::RST_SCALE;
			encoder_scale <= apf_pkg::RST_SCALE;
			follower_scale <= apf_pkg::RST_RATIO;
			secondary_ratio <= apf_pkg::RST_RATIO;
			for (int i = 0; i < 3; i++)
				line_setup[i] <= apf_pkg::RST_LINE;
		end else begin
			if (wr_hit(addr, apf_pkg::OFS_CONTROL, wr_en))
				ctrl <= apf_pkg::apf_ctrl_type'(wr_data[5:0]);
			if (wr_hit(addr, apf_pkg::OFS_MOTOR_SCALE, wr_en))
				motor_scale <= wr_data;
			if (wr_hit(addr, apf_pkg::OFS_ENCODER_SCALE, wr_en))
				encoder_scale <= wr_data;
			if (wr_hit(addr, apf_pkg::OFS_FOLLOWER_SCALE, wr_en))
				follower_scale <= wr_data;
			if (wr_hit(addr, apf_pkg::OFS_SEC_RATIO, wr_en) && ratio_ok)
				secondary_ratio <= wr_data;
			for (int i = 0; i < 3; i++)
				if (wr_hit(addr, apf_pkg::OFS_LINE0 + 8'(4 * i), wr_en))
					line_setup[i] <= apf_pkg::apf_line_type'(wr_data[10:0]);
		end
	end

	// error code: a new error wins over a clearing write in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			error_code <= apf_pkg::ERR_NONE;
		end else if (wr_hit(addr, apf_pkg::OFS_SEC_RATIO, wr_en) && !ratio_ok) begin
			error_code <= apf_pkg::ERR_RATIO_RANGE;
		end else if (wr_hit(addr, apf_pkg::OFS_ERROR, wr_en)) begin
			error_code <= apf_pkg::ERR_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			fault_lamp <= 1'b0;
		else
			fault_lamp <= ctrl.fault_lamp_enable && (error_code != apf_pkg::ERR_NONE);
	end

	// relative move: steps left and direction; new command replaces the old one
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			move_left <= 32'h0;
			move_dir <= 1'b1;
		end else if (wr_hit(addr, apf_pkg::OFS_MOVE, wr_en)) begin
			move_left <= move_prod[31:0];
			move_dir <= !wr_data[31];
		end else if (evt[0] && !fol_active) begin
			move_left <= move_left - 32'h1;
		end
	end

	// step pulse shaping for primary (0) and secondary (1) drives
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			step_hi <= 2'h0;
			step_dir <= 2'h3;
			for (int c = 0; c < 2; c++)
				gap[c] <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (evt[c]) begin
					gap[c] <= apf_pkg::GAP_W'(apf_pkg::STEP_GAP_CYC - 1);
					step_hi[c] <= 1'b1;
					step_dir[c] <= evt_dir[c];
				end else begin
					if (gap[c] != '0)
						gap[c] <= gap[c] - 1'b1;
					if (gap[c] == apf_pkg::GAP_W'(apf_pkg::STEP_GAP_CYC - apf_pkg::STEP_HIGH_CYC))
						step_hi[c] <= 1'b0;
				end
			end
		end
	end

	assign step_out = step_hi[0];
	assign dir_out = step_dir[0];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pair_oe <= 3'h0;
			pair_out_a <= 3'h0;
			pair_out_b <= 3'h0;
		end else begin
			for (int p = 0; p < 3; p++)
				pair_oe[p] <= line_setup[p].is_output;
			// step on a, direction on b
			pair_out_a <= 3'h0;
			pair_out_b <= 3'h0;
			if (sec_active && sec_on_15) begin
				pair_out_a[1] <= step_hi[1];
				pair_out_b[1] <= step_dir[1];
			end else if (sec_active) begin
				pair_out_a[0] <= step_hi[1];
				pair_out_b[0] <= step_dir[1];
			end
		end
	end

	// input history for edge decode
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prev_a <= 3'h0;
			prev_b <= 3'h0;
		end else begin
			prev_a <= pair_in_a;
			prev_b <= pair_in_b;
		end
	end

	// counters; a software write presets them and takes priority
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			step_pulse_counter <= 32'h0;
			encoder_pulse_counter <= 32'h0;
		end else begin
			if (wr_hit(addr, apf_pkg::OFS_STEP_CNT, wr_en))
				step_pulse_counter <= wr_data;
			else if (evt[0])
				step_pulse_counter <= evt_dir[0] ? step_pulse_counter + 32'h1 : step_pulse_counter - 32'h1;
			if (wr_hit(addr, apf_pkg::OFS_ENC_CNT, wr_en))
				encoder_pulse_counter <= wr_data;
			else if (enc_evt.pulse)
				encoder_pulse_counter <= enc_evt.dir ? encoder_pulse_counter + 32'h1
					: encoder_pulse_counter - 32'h1;
		end
	end

	// position divider runs continuously; a zero scale gives position zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_state <= DIV_IDLE;
			div_quo <= 32'h0;
			div_rem <= 32'h0;
			div_den <= apf_pkg::RST_SCALE;
			div_cnt <= 5'h0;
			div_neg <= 1'b0;
			position_user_units <= 32'h0;
		end else begin
			unique case (div_state)
				DIV_IDLE: begin
					div_rem <= 32'h0;
					div_cnt <= 5'h1F;
					if (ctrl.encoder_feedback_enable) begin
						div_neg <= encoder_pulse_counter[31];
						div_quo <= apf_pkg::apf_abs(encoder_pulse_counter);
						div_den <= encoder_scale;
					end else begin
						div_neg <= step_pulse_counter[31];
						div_quo <= apf_pkg::apf_abs(step_pulse_counter);
						div_den <= motor_scale;
					end
					div_state <= DIV_RUN;
				end
				DIV_RUN: begin
					if (div_sh >= {1'b0, div_den}) begin
						div_rem <= 32'(div_sh - {1'b0, div_den});
						div_quo <= {div_quo[30:0], 1'b1};
					end else begin
						div_rem <= div_sh[31:0];
						div_quo <= {div_quo[30:0], 1'b0};
					end
					div_cnt <= div_cnt - 5'h1;
					if (div_cnt == 5'h0)
						div_state <= DIV_DONE;
				end
				DIV_DONE: begin
					if (div_den == 32'h0)
						position_user_units <= 32'h0;
					else
						position_user_units <= div_neg ? 32'(-div_quo) : div_quo;
					div_state <= DIV_IDLE;
				end
			endcase
		end
	end

	// read data stands for exactly one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_b || !rd_en) begin
			rd_data <= 32'h0;
		end else begin
			unique case (addr)
				apf_pkg::OFS_CONTROL: rd_data <= 32'(ctrl);
				apf_pkg::OFS_MOTOR_SCALE: rd_data <= motor_scale;
				apf_pkg::OFS_ENCODER_SCALE: rd_data <= encoder_scale;
				apf_pkg::OFS_FOLLOWER_SCALE: rd_data <= follower_scale;
				apf_pkg::OFS_SEC_RATIO: rd_data <= secondary_ratio;
				apf_pkg::OFS_MOVE: rd_data <= move_left;
				apf_pkg::OFS_STEP_CNT: rd_data <= step_pulse_counter;
				apf_pkg::OFS_ENC_CNT: rd_data <= encoder_pulse_counter;
				apf_pkg::OFS_POSITION: rd_data <= position_user_units;
				apf_pkg::OFS_ERROR: rd_data <= 32'(error_code);
				apf_pkg::OFS_LINE0: rd_data <= 32'(line_setup[0]);
				apf_pkg::OFS_LINE0 + 8'h04: rd_data <= 32'(line_setup[1]);
				apf_pkg::OFS_LINE0 + 8'h08: rd_data <= 32'(line_setup[2]);
				apf_pkg::OFS_STATUS: rd_data <= {28'h0, fol_active, sec_active, move_left != 32'h0,
					div_state != DIV_IDLE};
				default: rd_data <= 32'h0;
			endcase
		end
	end

	a_step_count_up: assert property (@(posedge clk) disable iff (!rst_b)
		evt[0] && evt_dir[0] && !wr_en |=> step_pulse_counter == $past(step_pulse_counter) + 32'h1)
		else $error("step counter missed a forward step");
	a_motor_divisor: assert property (@(posedge clk) disable iff (!rst_b)
		div_state == DIV_IDLE && !ctrl.encoder_feedback_enable |=> div_den == $past(motor_scale))
		else $error("position not divided by motor scale");
	a_encoder_divisor: assert property (@(posedge clk) disable iff (!rst_b)
		div_state == DIV_IDLE && ctrl.encoder_feedback_enable |=> div_den == $past(encoder_scale))
		else $error("position not divided by encoder scale");
	a_encoder_edge_count: assert property (@(posedge clk) disable iff (!rst_b)
		enc_evt.pulse && !enc_evt.dir && !wr_en
		|=> encoder_pulse_counter == $past(encoder_pulse_counter) - 32'h1)
		else $error("encoder counter missed a reverse edge");
	a_follower_only: assert property (@(posedge clk) disable iff (!rst_b)
		!ctrl.follower_enable |=> !fol_out.pulse)
		else $error("follower step while follower mode off");
	a_sec_idle: assert property (@(posedge clk) disable iff (!rst_b)
		!sec_active ##1 !sec_active |-> !evt[1])
		else $error("secondary step while ratio mode off");
	a_ratio_refused: assert property (@(posedge clk) disable iff (!rst_b)
		wr_en && addr == apf_pkg::OFS_SEC_RATIO && !ratio_ok
		|=> error_code == apf_pkg::ERR_RATIO_RANGE && $stable(secondary_ratio))
		else $error("out of range ratio was not refused");
	a_fault_lamp_on: assert property (@(posedge clk) disable iff (!rst_b)
		(ctrl.fault_lamp_enable && error_code != apf_pkg::ERR_NONE) [*2] |-> fault_lamp)
		else $error("fault lamp dark with error present");
	a_step_width: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(step_out) |-> ##49 step_out ##1 !step_out)
		else $error("primary step high time wrong");
endmodule

// [verilog/apf_pkg.sv]
// Purpose: shared constants, carriers and helpers of the axis position and ratio follower
// Assumes: 50 MHz clock, 32-bit register port, ratios as signed Q16.16
// Notes: all register offsets are byte addresses on the plain register port
package apf_pkg;
	// clock and step timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int STEP_GAP_NS = 2000; // least time between two steps of one drive
	localparam int STEP_HIGH_NS = 1000; // step clock high time
	localparam int STEP_GAP_CYC = (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_HIGH_CYC = (STEP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_W = $clog2(STEP_GAP_CYC + 1);

	// register offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MOTOR_SCALE = 8'h04;
	localparam logic [7:0] OFS_ENCODER_SCALE = 8'h08;
	localparam logic [7:0] OFS_FOLLOWER_SCALE = 8'h0C;
	localparam logic [7:0] OFS_SEC_RATIO = 8'h10;
	localparam logic [7:0] OFS_MOVE = 8'h14;
	localparam logic [7:0] OFS_STEP_CNT = 8'h18;
	localparam logic [7:0] OFS_ENC_CNT = 8'h1C;
	localparam logic [7:0] OFS_POSITION = 8'h20;
	localparam logic [7:0] OFS_ERROR = 8'h24;
	localparam logic [7:0] OFS_LINE0 = 8'h28; // pair 13-14, then 15-16, 17-18 every four bytes
	localparam logic [7:0] OFS_STATUS = 8'h34;

	// values after reset and fixed codes
	localparam logic [31:0] RST_SCALE = 32'h0000_0001;
	localparam logic [31:0] RST_RATIO = 32'h0001_0000; // 1.0
	localparam logic [31:0] RATIO_ONE = 32'h0001_0000;
	localparam logic signed [31:0] RATIO_MAX = 32'sh0002_0000;
	localparam logic signed [31:0] RATIO_MIN = 32'shFFFE_0000;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_RATIO_RANGE = 16'h232C;
	localparam logic [2:0] CLK_QUAD = 3'h1;
	localparam logic [2:0] CLK_STEP_DIR = 3'h2;

	typedef struct packed {
		logic [1:0] follower_source; // 0: pair 13-14, 1: 15-16, 2: 17-18
		logic fault_lamp_enable;
		logic secondary_ratio_enable;
		logic follower_enable;
		logic encoder_feedback_enable;
	} apf_ctrl_type;

	typedef struct packed {
		logic ratio;
		logic [2:0] clk_type;
		logic edge_trig;
		logic high_true;
		logic is_output;
		logic [3:0] io_type;
	} apf_line_type;

	typedef struct packed {
		logic pulse;
		logic dir; // 1 = forward
	} apf_step_type;

	localparam apf_ctrl_type RST_CTRL = '0;
	localparam apf_line_type RST_LINE = '{ratio: 1'b0, clk_type: CLK_QUAD, edge_trig: 1'b1,
		high_true: 1'b0, is_output: 1'b0, io_type: 4'h0};

	function automatic logic [31:0] apf_abs(logic [31:0] v);
		return v[31] ? 32'(-v) : v;
	endfunction

	// one count per edge of either channel; {a,b} in bit 1 and bit 0
	function automatic apf_step_type quad_step(logic [1:0] prev, logic [1:0] now);
		apf_step_type s;
		s.pulse = ^(prev ^ now);
		s.dir = ~(prev[1] ^ now[0]);
		return s;
	endfunction
endpackage

// [verilog/apf_ratio_scaler.sv]
// Purpose: scales a stream of step events by a signed Q16.16 ratio
// Assumes: at most one input event per cycle
// Notes: emits only while out_ready, so bursts wait in the accumulator
`timescale 1ns/1ps
module apf_ratio_scaler #(
	parameter int ACC_W = 34
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic [31:0] ratio,
	input wire apf_pkg::apf_step_type in_step,
	input wire logic out_ready,
	output apf_pkg::apf_step_type out_step
);
	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] next_acc;
	logic fire;

	// add the ratio magnitude per input event; remainder stays for the next one
	always_comb begin
		next_acc = acc;
		if (in_step.pulse)
			next_acc = acc + ACC_W'(apf_pkg::apf_abs(ratio));
		fire = out_ready && !out_step.pulse && (next_acc >= ACC_W'(apf_pkg::RATIO_ONE));
	end

	always_ff @(posedge clk) begin
		if (!rst_b || !enable) begin
			acc <= '0;
		end else if (fire) begin
			acc <= next_acc - ACC_W'(apf_pkg::RATIO_ONE);
		end else begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			out_step <= '0;
		end else begin
			out_step.pulse <= enable && fire;
			if (in_step.pulse)
				out_step.dir <= in_step.dir ^ ratio[31];
		end
	end

	a_ratio_direction: assert property (@(posedge clk) disable iff (!rst_b)
		enable && in_step.pulse |=> out_step.dir == ($past(in_step.dir) ^ $past(ratio[31])))
		else $error("scaled direction does not follow ratio sign");
endmodule

// [verification/apf_enc_model.sv]
// Purpose: quadrature encoder or external clock standing on one differential pair
// Assumes: one edge per request, channel a leads channel b when turning forward
// Notes: lines rest at their last phase between requests, as a shaft at rest does
`timescale 1ns/1ps
module apf_enc_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic step_req,
	input wire logic fwd,
	output logic a,
	output logic b
);
	logic [1:0] ph;
	// phase walk; only one channel changes per request so no count is lost
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ph <= 2'h0;
		end else if (step_req) begin
			ph <= fwd ? ph + 2'h1 : ph - 2'h1;
		end
	end
	assign a = ph[1] ^ ph[0]; // 0,1,1,0 leads b by a quarter
	assign b = ph[1];
endmodule

// [verification/tb.sv]
// Purpose: self-checking bench of the axis position and ratio follower
// Assumes: 50 MHz clock, register port read data one cycle after the strobe
// Notes: pair 2 lines are held low; pairs 0 and 1 carry encoder models
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0000_0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rd_data;
	logic [2:0] pair_in_a, pair_in_b, pair_out_a, pair_out_b, pair_oe;
	logic step_out, dir_out, fault_lamp;
	logic [1:0] req = 2'h0;
	logic fwd = 1'b1;
	logic [1:0] ea, eb;
	logic p_s = 1'b0;
	logic p_x = 1'b0;
	logic sec_dir = 1'b1;
	int n_step = 0;
	int n_sec = 0;
	int n_errors = 0;
	int tests_run = 0;
	logic [31:0] d;
	int s;

	initial begin
		forever #10 clk = ~clk;
	end

	// a pair driven by the block wins over the model on the shared wire
	assign pair_in_a = (pair_oe & pair_out_a) | (~pair_oe & {1'b0, ea});
	assign pair_in_b = (pair_oe & pair_out_b) | (~pair_oe & {1'b0, eb});

	apf_axis_follower uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .pair_in_a(pair_in_a), .pair_in_b(pair_in_b),
		.pair_out_a(pair_out_a), .pair_out_b(pair_out_b), .pair_oe(pair_oe), .step_out(step_out),
		.dir_out(dir_out), .fault_lamp(fault_lamp));
	apf_enc_model enc0 (.clk(clk), .rst_b(rst_b), .step_req(req[0]), .fwd(fwd), .a(ea[0]), .b(eb[0]));
	apf_enc_model enc1 (.clk(clk), .rst_b(rst_b), .step_req(req[1]), .fwd(fwd), .a(ea[1]), .b(eb[1]));

	// step counting on both drives; secondary direction kept at each rise
	always @(posedge clk) begin
		p_s <= step_out;
		p_x <= pair_out_a[1];
		if (step_out && !p_s) n_step <= n_step + 1;
		if (pair_out_a[1] && !p_x) begin
			n_sec <= n_sec + 1;
			sec_dir <= pair_out_b[1];
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask

	// poll until the move is done; the divider never rests, so only the move bit is waited on
	task automatic idle;
		logic [31:0] st;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 2000; i++) begin
			rd(apf_pkg::OFS_STATUS, st);
			if (st[1] === 1'b0) return;
		end
		chk("move idle", 32'h0, {30'h0, st[1], 1'b0});
	endtask

	task automatic enc(input int idx, input int n, input logic f);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			fwd <= f;
			req[idx] <= 1'b1;
			@(posedge clk);
			req[idx] <= 1'b0;
			repeat (120) @(posedge clk);
		end
	endtask

	task automatic t_reset;
		rd(apf_pkg::OFS_CONTROL, d); chk("control", 32'h0, d);
		rd(apf_pkg::OFS_SEC_RATIO, d); chk("ratio", apf_pkg::RST_RATIO, d);
		rd(apf_pkg::OFS_ERROR, d); chk("error", 32'h0, d);
		chk("dir", 32'h1, {31'h0, dir_out});
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, d); chk("unmapped", 32'h0, d);
	endtask

	task automatic t_move;
		s = n_step;
		wr(apf_pkg::OFS_MOTOR_SCALE, 32'h0000_0003);
		wr(apf_pkg::OFS_MOVE, 32'h0000_0002);
		idle();
		rd(apf_pkg::OFS_STEP_CNT, d); chk("step count", 32'h6, d);
		chk("steps", 32'h6, 32'(n_step - s));
		// a count may just miss a divider round, so allow two rounds
		repeat (80) @(posedge clk);
		rd(apf_pkg::OFS_POSITION, d); chk("position", 32'h2, d);
	endtask

	task automatic t_enc;
		enc(0, 8, 1'b1);
		enc(0, 2, 1'b0);
		rd(apf_pkg::OFS_ENC_CNT, d); chk("enc count", 32'h6, d);
		wr(apf_pkg::OFS_ENCODER_SCALE, 32'h0000_0003); // same scaling as motor
		wr(apf_pkg::OFS_CONTROL, 32'h0000_0001);
		wr(apf_pkg::OFS_MOVE, 32'h0000_0001);
		idle();
		rd(apf_pkg::OFS_STEP_CNT, d); chk("step count ee", 32'h9, d);
		repeat (80) @(posedge clk);
		rd(apf_pkg::OFS_POSITION, d); chk("position ee", 32'h2, d);
		wr(apf_pkg::OFS_CONTROL, 32'h0000_0000);
	endtask

	task automatic t_follow;
		wr(apf_pkg::OFS_LINE0 + 8'h04, 32'h0000_04C5);
		wr(apf_pkg::OFS_FOLLOWER_SCALE, 32'h0000_8000);
		wr(apf_pkg::OFS_CONTROL, 32'h0000_0010);
		s = n_step;
		enc(1, 4, 1'b1);
		chk("follow off", 32'h0, 32'(n_step - s));
		wr(apf_pkg::OFS_CONTROL, 32'h0000_0012);
		s = n_step;
		enc(1, 7, 1'b1);
		repeat (300) @(posedge clk);
		chk("follow half", 32'h3, 32'(n_step - s));
		enc(1, 1, 1'b1);
		repeat (300) @(posedge clk);
		chk("follow carry", 32'h4, 32'(n_step - s));
		chk("follow dir", 32'h1, {31'h0, dir_out});
		wr(apf_pkg::OFS_CONTROL, 32'h0000_0000);
	endtask

	task automatic t_second;
		wr(apf_pkg::OFS_LINE0 + 8'h04, 32'h0000_0555);
		wr(apf_pkg::OFS_SEC_RATIO, 32'hFFFF_8000);
		wr(apf_pkg::OFS_MOTOR_SCALE, 32'h0000_0001);
		wr(apf_pkg::OFS_CONTROL, 32'h0000_0004);
		s = n_sec;
		wr(apf_pkg::OFS_MOVE, 32'h0000_0004);
		idle();
		repeat (300) @(posedge clk);
		chk("pair oe", 32'h2, {29'h0, pair_oe});
		chk("sec steps", 32'h2, 32'(n_sec - s));
		chk("sec dir", 32'h0, {31'h0, sec_dir});
	endtask

	task automatic t_range;
		wr(apf_pkg::OFS_SEC_RATIO, 32'h0002_0000);
		rd(apf_pkg::OFS_ERROR, d); chk("err high", 32'h232C, d);
		wr(apf_pkg::OFS_ERROR, 32'h0);
		wr(apf_pkg::OFS_SEC_RATIO, 32'hFFFE_0000);
		rd(apf_pkg::OFS_ERROR, d); chk("err low", 32'h232C, d);
		rd(apf_pkg::OFS_SEC_RATIO, d); chk("ratio kept", 32'hFFFF_8000, d);
		chk("lamp dark", 32'h0, {31'h0, fault_lamp});
		wr(apf_pkg::OFS_CONTROL, 32'h0000_000C);
		repeat (2) @(posedge clk);
		chk("lamp lit", 32'h1, {31'h0, fault_lamp});
		wr(apf_pkg::OFS_ERROR, 32'h0);
		repeat (2) @(posedge clk);
		chk("lamp clear", 32'h0, {31'h0, fault_lamp});
	endtask

	task automatic summarize;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// the whole sequence needs about 5000 cycles; allow several times that
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		summarize();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_move();
		t_enc();
		t_follow();
		t_second();
		t_range();
		summarize();
	end
endmodule
